/* File: inc/plr_defs.vh */
// constants shared by the priority level register block
`ifndef PLR_DEFS_VH
`define PLR_DEFS_VH

// ==========================================================
// bus geometry
`define PLR_ADDR_W 8
`define PLR_DATA_W 32
`define PLR_STRB_W 4
`define PLR_REG_W 16
`define PLR_NUM_SRC 24

// ==========================================================
// register indices, byte address is four times the index
`define PLR_IDX_BANK7 6'h07
`define PLR_IDX_BANK8 6'h08
`define PLR_IDX_BANK9 6'h09
`define PLR_IDX_PEND 6'h10

// ==========================================================
// reset values and writable bit masks
`define PLR_BANK_RESET 16'h0000
`define PLR_WMASK_FULL 16'hffff
`define PLR_WMASK_BANK8 16'hf3ff
`define PLR_UPPER_ZERO16 16'h0000
`define PLR_UPPER_ZERO8 8'h00

// ==========================================================
// field encodings and delivered levels
`define PLR_FIELD_MASKED 2'h0
`define PLR_FIELD_L0 2'h1
`define PLR_FIELD_L1 2'h2
`define PLR_FIELD_L2 2'h3
`define PLR_LEVEL0 2'h0
`define PLR_LEVEL1 2'h1
`define PLR_LEVEL2 2'h2
`define PLR_HOT_NONE 3'h0
`define PLR_HOT_L0 3'h1
`define PLR_HOT_L1 3'h2
`define PLR_HOT_L2 3'h4

// ==========================================================
// bus responses
`define PLR_RESP_OKAY 2'h0
`define PLR_RESP_DECERR 2'h3
`define PLR_ZERO32 32'h00000000

`endif

/* File: core/plr_axil_slave.v */
// axi4-lite slave front end producing single-cycle register strobes
`timescale 1ns/10ps
`include "plr_defs.vh"

module plr_axil_slave (
   input wire sys_clk_i,
   input wire resetn_i,
   input wire [`PLR_ADDR_W-1:0] s_axi_awaddr_i,
   input wire s_axi_awvalid_i,
   output wire s_axi_awready_o,
   input wire [`PLR_DATA_W-1:0] s_axi_wdata_i,
   input wire [`PLR_STRB_W-1:0] s_axi_wstrb_i,
   input wire s_axi_wvalid_i,
   output wire s_axi_wready_o,
   output wire [1:0] s_axi_bresp_o,
   output wire s_axi_bvalid_o,
   input wire s_axi_bready_i,
   input wire [`PLR_ADDR_W-1:0] s_axi_araddr_i,
   input wire s_axi_arvalid_i,
   output wire s_axi_arready_o,
   output wire [`PLR_DATA_W-1:0] s_axi_rdata_o,
   output wire [1:0] s_axi_rresp_o,
   output wire s_axi_rvalid_o,
   input wire s_axi_rready_i,
   output wire wr_en_o,
   output wire [`PLR_ADDR_W-1:0] wr_addr_o,
   output wire [`PLR_DATA_W-1:0] wr_data_o,
   output wire [`PLR_STRB_W-1:0] wr_strb_o,
   input wire wr_ok_i,
   output wire rd_en_o,
   output wire [`PLR_ADDR_W-1:0] rd_addr_o,
   input wire [`PLR_DATA_W-1:0] rd_data_i,
   input wire rd_ok_i
);

   reg aw_full_reg;
   reg w_full_reg;
   reg ar_full_reg;
   reg [`PLR_ADDR_W-1:0] awaddr_reg;
   reg [`PLR_DATA_W-1:0] wdata_reg;
   reg [`PLR_STRB_W-1:0] wstrb_reg;
   reg [`PLR_ADDR_W-1:0] araddr_reg;
   reg bvalid_reg;
   reg [1:0] bresp_reg;
   reg rvalid_reg;
   reg [1:0] rresp_reg;
   reg [`PLR_DATA_W-1:0] rdata_reg;

   // ==========================================================
   // handshakes
   // address and data are held separately so either may come first
   assign s_axi_awready_o = ~aw_full_reg & ~bvalid_reg;
   assign s_axi_wready_o = ~w_full_reg & ~bvalid_reg;
   assign s_axi_arready_o = ~ar_full_reg & ~rvalid_reg;
   assign s_axi_bvalid_o = bvalid_reg;
   assign s_axi_bresp_o = bresp_reg;
   assign s_axi_rvalid_o = rvalid_reg;
   assign s_axi_rresp_o = rresp_reg;
   assign s_axi_rdata_o = rdata_reg;

   // strobes to the register file, one cycle each
   assign wr_en_o = aw_full_reg & w_full_reg;
   assign wr_addr_o = awaddr_reg;
   assign wr_data_o = wdata_reg;
   assign wr_strb_o = wstrb_reg;
   assign rd_en_o = ar_full_reg;
   assign rd_addr_o = araddr_reg;

   // ==========================================================
   // write channel
   always @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awaddr_reg <= {`PLR_ADDR_W{1'b0}};
         wdata_reg <= `PLR_ZERO32;
         wstrb_reg <= {`PLR_STRB_W{1'b0}};
         bvalid_reg <= 1'b0;
         bresp_reg <= `PLR_RESP_OKAY;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_full_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_full_reg <= 1'b1;
            wdata_reg <= s_axi_wdata_i;
            wstrb_reg <= s_axi_wstrb_i;
         end
         // response only once both halves are in
         if (wr_en_o) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok_i ? `PLR_RESP_OKAY : `PLR_RESP_DECERR;
         end else if (bvalid_reg && s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // ==========================================================
   // read channel
   always @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         ar_full_reg <= 1'b0;
         araddr_reg <= {`PLR_ADDR_W{1'b0}};
         rvalid_reg <= 1'b0;
         rresp_reg <= `PLR_RESP_OKAY;
         rdata_reg <= `PLR_ZERO32;
      end else begin
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            ar_full_reg <= 1'b1;
            araddr_reg <= s_axi_araddr_i;
         end
         if (rd_en_o) begin
            ar_full_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_data_i;
            rresp_reg <= rd_ok_i ? `PLR_RESP_OKAY : `PLR_RESP_DECERR;
         end else if (rvalid_reg && s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

endmodule

/* File: core/plr_level_map.v */
// one source: masks its request and turns its field into a level
`timescale 1ns/10ps
`include "plr_defs.vh"

module plr_level_map (
   input wire sys_clk_i,
   input wire resetn_i,
   input wire [1:0] field_i,
   input wire req_i,
   output reg req_o,
   output reg [1:0] level_o,
   output reg [2:0] hot_o
);

   // ==========================================================
   // field decode
   // R1 field to level
   function [1:0] plr_decode;
      input [1:0] field;
      begin
         case (field)
            `PLR_FIELD_L0: plr_decode = `PLR_LEVEL0;
            `PLR_FIELD_L1: plr_decode = `PLR_LEVEL1;
            // R2 no level above two
            `PLR_FIELD_L2: plr_decode = `PLR_LEVEL2;
            default: plr_decode = `PLR_LEVEL0;
         endcase
      end
   endfunction

   function [2:0] plr_onehot;
      input [1:0] field;
      begin
         case (field)
            `PLR_FIELD_L0: plr_onehot = `PLR_HOT_L0;
            `PLR_FIELD_L1: plr_onehot = `PLR_HOT_L1;
            `PLR_FIELD_L2: plr_onehot = `PLR_HOT_L2;
            default: plr_onehot = `PLR_HOT_NONE;
         endcase
      end
   endfunction

   // ==========================================================
   // registered presentation to the arbiter
   // R15 mask or present request
   always @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         req_o <= 1'b0;
         level_o <= `PLR_LEVEL0;
         hot_o <= `PLR_HOT_NONE;
      end else begin
         req_o <= req_i & (field_i != `PLR_FIELD_MASKED);
         level_o <= plr_decode(field_i);
         hot_o <= req_i ? plr_onehot(field_i) : `PLR_HOT_NONE;
      end
   end

endmodule

/* File: core/plr_priority_regs.v */
// three priority level banks for timer, serial, pwm and adc sources
//
// Behaviour
// R1 - field 00 masks the source, 01 level 0, 10 level 1, 11 level 2
// R2 - no field can select a level above 2
// R3 - all fields reset to zero, so every source starts masked
// R4 - bits 11..10 of the second bank read zero and ignore writes
// R5 - first bank: 15..14 timer A ch0, 13..12 timer B ch3, 11..10 timer B ch2
// R6 - first bank: 9..8 timer B ch1, 7..6 timer B ch0
// R7 - first bank: 5..4 timer C ch3, 3..2 timer C ch2, 1..0 timer C ch1
// R8 - second bank: 15..14 serial rx full, 13..12 serial rx error
// R9 - second bank: 9..8 serial tx idle, 7..6 serial tx empty
// R10 - second bank: 5..4 timer A ch3, 3..2 timer A ch2, 1..0 timer A ch1
// R11 - third bank: 15..14 pwm A fault, 13..12 pwm B fault
// R12 - third bank: 11..10 pwm A reload, 9..8 pwm B reload
// R13 - third bank: 7..6 adc A zero cross, 5..4 adc B zero cross
// R14 - third bank: 3..2 adc A done, 1..0 adc B done
// R15 - a request with nonzero field goes out at its level, else masked
// R16 - software sets level 2 on a source before making it fast
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "plr_defs.vh"

module plr_priority_regs (
   input wire sys_clk_i,
   input wire resetn_i,
   input wire [`PLR_ADDR_W-1:0] s_axi_awaddr_i,
   input wire s_axi_awvalid_i,
   output wire s_axi_awready_o,
   input wire [`PLR_DATA_W-1:0] s_axi_wdata_i,
   input wire [`PLR_STRB_W-1:0] s_axi_wstrb_i,
   input wire s_axi_wvalid_i,
   output wire s_axi_wready_o,
   output wire [1:0] s_axi_bresp_o,
   output wire s_axi_bvalid_o,
   input wire s_axi_bready_i,
   input wire [`PLR_ADDR_W-1:0] s_axi_araddr_i,
   input wire s_axi_arvalid_i,
   output wire s_axi_arready_o,
   output wire [`PLR_DATA_W-1:0] s_axi_rdata_o,
   output wire [1:0] s_axi_rresp_o,
   output wire s_axi_rvalid_o,
   input wire s_axi_rready_i,
   input wire [`PLR_NUM_SRC-1:0] irq_req_i,
   output wire [`PLR_NUM_SRC-1:0] src_req_o,
   output wire [2*`PLR_NUM_SRC-1:0] src_level_o,
   output wire [`PLR_NUM_SRC-1:0] pend_lvl0_o,
   output wire [`PLR_NUM_SRC-1:0] pend_lvl1_o,
   output wire [`PLR_NUM_SRC-1:0] pend_lvl2_o
);

   // ==========================================================
   // declarations
   reg [`PLR_REG_W-1:0] timer_ab_c_priority_bank_reg;
   reg [`PLR_REG_W-1:0] serial_timer_a_priority_bank_reg;
   reg [`PLR_REG_W-1:0] pwm_adc_priority_bank_reg;
   reg [`PLR_DATA_W-1:0] rd_data;
   reg rd_ok;
   reg wr_ok;
   wire wr_en;
   wire [`PLR_ADDR_W-1:0] wr_addr;
   wire [`PLR_DATA_W-1:0] wr_data;
   wire [`PLR_STRB_W-1:0] wr_strb;
   wire rd_en;
   wire [`PLR_ADDR_W-1:0] rd_addr;
   wire [5:0] wr_idx;
   wire [5:0] rd_idx;
   wire [3*`PLR_REG_W-1:0] all_fields;
   wire [3*`PLR_NUM_SRC-1:0] lvl_hot;

   // ==========================================================
   // helpers
   // byte-lane merge, limited to the bits a bank really has
   function [`PLR_REG_W-1:0] plr_merge;
      input [`PLR_REG_W-1:0] old;
      input [`PLR_REG_W-1:0] din;
      input [1:0] strb;
      input [`PLR_REG_W-1:0] wmask;
      reg [`PLR_REG_W-1:0] lane;
      begin
         lane = {{8{strb[1]}}, {8{strb[0]}}};
         plr_merge = ((old & ~lane) | (din & lane)) & wmask;
      end
   endfunction

   // word index from a byte address, low two bits ignored
   function [5:0] plr_index;
      input [`PLR_ADDR_W-1:0] addr;
      begin
         plr_index = addr[`PLR_ADDR_W-1:2];
      end
   endfunction

   // ==========================================================
   // bus front end
   plr_axil_slave u_bus (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .s_axi_awaddr_i(s_axi_awaddr_i),
      .s_axi_awvalid_i(s_axi_awvalid_i),
      .s_axi_awready_o(s_axi_awready_o),
      .s_axi_wdata_i(s_axi_wdata_i),
      .s_axi_wstrb_i(s_axi_wstrb_i),
      .s_axi_wvalid_i(s_axi_wvalid_i),
      .s_axi_wready_o(s_axi_wready_o),
      .s_axi_bresp_o(s_axi_bresp_o),
      .s_axi_bvalid_o(s_axi_bvalid_o),
      .s_axi_bready_i(s_axi_bready_i),
      .s_axi_araddr_i(s_axi_araddr_i),
      .s_axi_arvalid_i(s_axi_arvalid_i),
      .s_axi_arready_o(s_axi_arready_o),
      .s_axi_rdata_o(s_axi_rdata_o),
      .s_axi_rresp_o(s_axi_rresp_o),
      .s_axi_rvalid_o(s_axi_rvalid_o),
      .s_axi_rready_i(s_axi_rready_i),
      .wr_en_o(wr_en),
      .wr_addr_o(wr_addr),
      .wr_data_o(wr_data),
      .wr_strb_o(wr_strb),
      .wr_ok_i(wr_ok),
      .rd_en_o(rd_en),
      .rd_addr_o(rd_addr),
      .rd_data_i(rd_data),
      .rd_ok_i(rd_ok)
   );

   assign wr_idx = plr_index(wr_addr);
   assign rd_idx = plr_index(rd_addr);

   // ==========================================================
   // write decode
   // the pending view is read-only, so a write there is refused
   always @* begin
      case (wr_idx)
         `PLR_IDX_BANK7: wr_ok = 1'b1;
         `PLR_IDX_BANK8: wr_ok = 1'b1;
         `PLR_IDX_BANK9: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // ==========================================================
   // priority banks
   // R3 all fields masked at reset
   always @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         timer_ab_c_priority_bank_reg <= `PLR_BANK_RESET;
         serial_timer_a_priority_bank_reg <= `PLR_BANK_RESET;
         pwm_adc_priority_bank_reg <= `PLR_BANK_RESET;
      end else if (wr_en) begin
         case (wr_idx)
            `PLR_IDX_BANK7: begin
               timer_ab_c_priority_bank_reg <= plr_merge(timer_ab_c_priority_bank_reg,
                  wr_data[`PLR_REG_W-1:0], wr_strb[1:0], `PLR_WMASK_FULL);
            end
            // R4 reserved pair stays zero
            `PLR_IDX_BANK8: begin
               serial_timer_a_priority_bank_reg <= plr_merge(serial_timer_a_priority_bank_reg,
                  wr_data[`PLR_REG_W-1:0], wr_strb[1:0], `PLR_WMASK_BANK8);
            end
            `PLR_IDX_BANK9: begin
               pwm_adc_priority_bank_reg <= plr_merge(pwm_adc_priority_bank_reg,
                  wr_data[`PLR_REG_W-1:0], wr_strb[1:0], `PLR_WMASK_FULL);
            end
            default: begin
               timer_ab_c_priority_bank_reg <= timer_ab_c_priority_bank_reg;
            end
         endcase
      end
   end

   // ==========================================================
   // read mux
   // upper half of each bank word and top byte of the pending word read zero; unmapped words answer decerr
   always @* begin
      rd_data = `PLR_ZERO32;
      rd_ok = 1'b1;
      case (rd_idx)
         `PLR_IDX_BANK7: rd_data = {`PLR_UPPER_ZERO16, timer_ab_c_priority_bank_reg};
         // R4 reserved bits read zero
         `PLR_IDX_BANK8: rd_data = {`PLR_UPPER_ZERO16, serial_timer_a_priority_bank_reg & `PLR_WMASK_BANK8};
         `PLR_IDX_BANK9: rd_data = {`PLR_UPPER_ZERO16, pwm_adc_priority_bank_reg};
         `PLR_IDX_PEND: rd_data = {`PLR_UPPER_ZERO8, src_req_o};
         default: begin
            rd_data = `PLR_ZERO32;
            rd_ok = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // source slots
   // slot k uses bits 2k+1..2k of the three banks laid end to end:
   // slots 0..7 first bank, 8..15 second, 16..23 third
   // R5 timer A ch0, timer B ch3 and ch2 slots
   // R6 timer B ch1 and ch0 slots
   // R7 timer C ch3..ch1 slots
   // R8 serial rx slots
   // R9 serial tx slots
   // R10 timer A ch3..ch1 slots
   // R11 pwm fault slots
   // R12 pwm reload slots
   // R13 adc zero cross slots
   // R14 adc done slots
   assign all_fields = {pwm_adc_priority_bank_reg,
                        serial_timer_a_priority_bank_reg & `PLR_WMASK_BANK8,
                        timer_ab_c_priority_bank_reg};

   // one mapper per slot; slot 13 has a field forced to zero and stays masked
   genvar k;
   generate
      for (k = 0; k < `PLR_NUM_SRC; k = k + 1) begin : g_src
         plr_level_map u_map (
            .sys_clk_i(sys_clk_i),
            .resetn_i(resetn_i),
            .field_i(all_fields[2*k+1:2*k]),
            .req_i(irq_req_i[k]),
            .req_o(src_req_o[k]),
            .level_o(src_level_o[2*k+1:2*k]),
            .hot_o(lvl_hot[3*k+2:3*k])
         );
         // per-level pending vectors for the arbiter
         assign pend_lvl0_o[k] = lvl_hot[3*k];
         assign pend_lvl1_o[k] = lvl_hot[3*k+1];
         assign pend_lvl2_o[k] = lvl_hot[3*k+2];
      end
   endgenerate

   // R16 level 2 is what a fast source must carry; nothing here forces it

endmodule

/* File: verif/plr_core_model.sv */
// behavioural core that takes the prioritized requests of the block
`timescale 1ns/10ps
`include "plr_defs.vh"

module plr_core_model (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic [`PLR_NUM_SRC-1:0] pend_lvl0_i,
   input wire logic [`PLR_NUM_SRC-1:0] pend_lvl1_i,
   input wire logic [`PLR_NUM_SRC-1:0] pend_lvl2_i,
   input wire logic [4:0] fast_slot_i,
   output logic [2:0] top_hot_o,
   output logic fast_take_o
);
   // ==========================================
   // arbitration view
   // latch one-hot of the highest pending level, level 2 wins
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         top_hot_o <= 3'h0;
         fast_take_o <= 1'b0;
      end else begin
         top_hot_o <= |pend_lvl2_i ? 3'h4 : (|pend_lvl1_i ? 3'h2 : (|pend_lvl0_i ? 3'h1 : 3'h0));
         fast_take_o <= pend_lvl2_i[fast_slot_i]; // other levels never take the fast path
      end
   end
endmodule

/* File: verif/plr_priority_regs_monitor.sv */
// assertions on the ports of the priority level register block
`timescale 1ns/10ps
`include "plr_defs.vh"

module plr_regs_monitor (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic [`PLR_DATA_W-1:0] s_axi_rdata_o,
   input wire logic [1:0] s_axi_rresp_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [`PLR_NUM_SRC-1:0] irq_req_i,
   input wire logic [`PLR_NUM_SRC-1:0] src_req_o,
   input wire logic [2*`PLR_NUM_SRC-1:0] src_level_o,
   input wire logic [`PLR_NUM_SRC-1:0] pend_lvl0_o,
   input wire logic [`PLR_NUM_SRC-1:0] pend_lvl1_o,
   input wire logic [`PLR_NUM_SRC-1:0] pend_lvl2_o
);
   logic [`PLR_NUM_SRC-1:0] lv_hi;
   logic [`PLR_NUM_SRC-1:0] lv_lo;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!resetn_i);
   // ==========================================
   // helpers
   // split packed levels so each bit can be tied to its pending flag
   always_comb begin
      for (int k = 0; k < `PLR_NUM_SRC; k++) begin
         lv_hi[k] = src_level_o[2*k+1];
         lv_lo[k] = src_level_o[2*k];
      end
   end
   sequence s_wr_taken;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid_i && s_axi_arready_o;
   endsequence
   // ==========================================
   // bus handshake
   a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid_o) else $error("no write response");
   a_read_answer: assert property (s_rd_taken |-> ##[1:2] s_axi_rvalid_o) else $error("no read response");
   a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data dropped");
   a_busy_refuse: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write taken while busy");
   // ==========================================
   // level coding
   // no level three
   a_no_level3: assert property ((lv_hi & lv_lo) == 0) else $error("level above two");
   a_lvl0_code: assert property (pend_lvl0_o == (src_req_o & ~lv_hi & ~lv_lo)) else $error("level 0 flag");
   a_lvl1_code: assert property (pend_lvl1_o == (src_req_o & lv_lo)) else $error("level 1 flag");
   a_lvl2_code: assert property (pend_lvl2_o == (src_req_o & lv_hi)) else $error("level 2 flag");
   a_masked_quiet: assert property (($past(irq_req_i) & ~src_req_o & (lv_hi | lv_lo)) == 0) else $error("level on masked");
   a_req_cause: assert property ((src_req_o & ~$past(irq_req_i)) == 0) else $error("request without input");
   a_reserved_slot: assert property (!src_req_o[13]) else $error("reserved slot active");
   a_reset_clear: assert property ($rose(resetn_i) |-> src_req_o == 0 && src_level_o == 0)
      else $error("outputs not cleared");
endmodule

bind plr_priority_regs plr_regs_monitor i_plr_regs_monitor (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
   .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
   .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rready_i(s_axi_rready_i), .irq_req_i(irq_req_i), .src_req_o(src_req_o), .src_level_o(src_level_o),
   .pend_lvl0_o(pend_lvl0_o), .pend_lvl1_o(pend_lvl1_o), .pend_lvl2_o(pend_lvl2_o));

/* File: verif/plr_priority_regs_tb.sv */
// self-checking bench for the priority level register block
`timescale 1ns/10ps
`include "plr_defs.vh"

module plr_priority_regs_tb;
   logic sys_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] s_axi_awaddr_i = 8'h00;
   logic [7:0] s_axi_araddr_i = 8'h00;
   logic [31:0] s_axi_wdata_i = 32'h00000000;
   logic [3:0] s_axi_wstrb_i = 4'h0;
   logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
   logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
   logic [23:0] irq_req_i = 24'hffffff;
   logic [4:0] fast_slot = 5'h00;
   wire logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   wire logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
   wire logic [31:0] s_axi_rdata_o;
   wire logic [23:0] src_req_o, pend_lvl0_o, pend_lvl1_o, pend_lvl2_o;
   wire logic [47:0] src_level_o;
   wire logic [2:0] top_hot;
   wire logic fast_take;
   int n_fail = 0;
   int checks_done = 0;

   // ==========================================
   // clock, design and core model
   always #2.5 sys_clk_i = ~sys_clk_i;
   plr_priority_regs i_plr_priority_regs (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
      .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
      .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
      .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
      .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
      .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
      .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .irq_req_i(irq_req_i),
      .src_req_o(src_req_o), .src_level_o(src_level_o), .pend_lvl0_o(pend_lvl0_o),
      .pend_lvl1_o(pend_lvl1_o), .pend_lvl2_o(pend_lvl2_o));
   plr_core_model i_plr_core_model (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .pend_lvl0_i(pend_lvl0_o),
      .pend_lvl1_i(pend_lvl1_o), .pend_lvl2_i(pend_lvl2_o), .fast_slot_i(fast_slot),
      .top_hot_o(top_hot), .fast_take_o(fast_take));

   // ==========================================
   // report helpers
   task automatic err(input string m);
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) $display("[ERR] %0t value %h expected %h", $time, got, exp);
      if (got !== exp) n_fail++;
   endtask
   task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
      checks_done++;
      if (got !== exp) err("bus response mismatch");
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic stop_test();
      if (n_fail == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ==========================================
   // axi4-lite master: each channel held until its own ready
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      int t = 0;
      bit aw = 0;
      bit w = 0;
      @(posedge sys_clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_wstrb_i <= s;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      while (!(aw && w) && t < 100) begin
         @(posedge sys_clk_i);
         t++;
         if (!aw && s_axi_awready_o === 1'b1) begin
            s_axi_awvalid_i <= 1'b0;
            aw = 1;
         end
         if (!w && s_axi_wready_o === 1'b1) begin
            s_axi_wvalid_i <= 1'b0;
            w = 1;
         end
      end
      // late ready lets the response be seen waiting
      repeat (2) @(posedge sys_clk_i);
      s_axi_bready_i <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         t++;
      end while (s_axi_bvalid_o !== 1'b1 && t < 100);
      r = s_axi_bresp_o;
      s_axi_bready_i <= 1'b0;
      if (t >= 100) err("write hang");
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int t = 0;
      @(posedge sys_clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         t++;
      end while (s_axi_arready_o !== 1'b1 && t < 100);
      s_axi_arvalid_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      s_axi_rready_i <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         t++;
      end while (s_axi_rvalid_o !== 1'b1 && t < 100);
      s_axi_rready_i <= 1'b0;
      if (t >= 100) err("read hang");
      chk_v(s_axi_rdata_o, ed);
      chk_r(s_axi_rresp_o, er);
   endtask

   // ==========================================
   // scenarios
   // every source requesting while all fields are cleared
   task automatic t_reset();
      for (int b = 0; b < 3; b++) rd_chk(8'h1c + 8'(4 * b), 32'h0, 2'h0);
      chk_v(32'(src_req_o), 32'h0);
   endtask
   // each slot through every code, then masked again
   task automatic t_slots();
      logic [7:0] a;
      logic [15:0] v;
      logic [1:0] r;
      logic q;
      for (int k = 0; k < 24; k++) begin
         a = 8'h1c + 8'(4 * (k / 8));
         q = (k != 13);
         for (int c = 1; c < 4; c++) begin
            v = 16'(c) << (2 * (k % 8));
            axi_wr(a, {16'h0000, v}, 4'hf, r);
            chk_r(r, 2'h0);
            wait_clk(3);
            chk_v(32'(src_req_o), 32'(q) << k);
            chk_v(32'(src_level_o[2*k +: 2]), q ? 32'(c - 1) : 32'h0);
            chk_v(32'(top_hot), q ? 32'(1 << (c - 1)) : 32'h0);
            rd_chk(a, q ? 32'(v) : 32'h0, 2'h0);
         end
         axi_wr(a, 32'h0, 4'hf, r);
         wait_clk(3);
         chk_v(32'(src_req_o), 32'h0);
      end
   endtask
   // wide writes, byte strobes, reserved bits and unmapped places
   task automatic t_masks();
      logic [1:0] r;
      axi_wr(8'h20, 32'hffffffff, 4'hf, r);
      rd_chk(8'h20, 32'h0000f3ff, 2'h0);
      axi_wr(8'h1c, 32'hffffffff, 4'hf, r);
      axi_wr(8'h1c, 32'h0, 4'h1, r);
      rd_chk(8'h1c, 32'h0000ff00, 2'h0);
      rd_chk(8'h30, 32'h0, 2'h3);
      axi_wr(8'h30, 32'h1, 4'hf, r);
      chk_r(r, 2'h3);
      axi_wr(8'h40, 32'h1, 4'hf, r);
      chk_r(r, 2'h3);
      rd_chk(8'h40, 32'h00dff0, 2'h0);
   endtask
   // fast slot at level two, then requests withdrawn
   task automatic t_fast_drop();
      fast_slot <= 5'h07;
      wait_clk(3);
      chk_v(32'(fast_take), 32'h1);
      irq_req_i <= 24'h000000;
      wait_clk(3);
      chk_v(32'(src_req_o), 32'h0);
      chk_v(32'(top_hot), 32'h0);
   endtask
   // second reset in mid-run clears programmed fields
   task automatic t_rereset();
      resetn_i <= 1'b0;
      wait_clk(3);
      resetn_i <= 1'b1;
      irq_req_i <= 24'hffffff;
      t_reset();
   endtask

   // ==========================================
   // main sequence and watchdog
   initial begin
      wait_clk(5);
      resetn_i <= 1'b1;
      t_reset();
      t_slots();
      t_masks();
      t_fast_drop();
      t_rereset();
      stop_test();
   end
   // cut a hang well past the expected run of a little over a thousand cycles
   initial begin
      #200000;
      err("watchdog expired");
      stop_test();
   end
endmodule
